// ===== src/mma_pkg.sv
// constants and types shared by the multiply-accumulate-and-move unit
// assumes one core clock and the decoder handing over the third opcode byte
package mma_pkg;
	localparam int ACC_W = 40;
	localparam int OP_W = 16;
	localparam int PROD_W = 32;
	localparam int ADDR_W = 16;
	localparam logic [7:0] FIRST_BYTE = 8'h93;
	localparam logic [7:0] OPC_U_ADD = 8'h18;
	localparam logic [7:0] OPC_U_ADD_RND = 8'h19;
	localparam logic [7:0] OPC_SU_ADD = 8'h58;
	localparam logic [7:0] OPC_SU_ADD_RND = 8'h59;
	localparam logic [7:0] OPC_SU_SUB = 8'h68;
	localparam logic [7:0] OPC_U_SUB = 8'h28;
	localparam logic [39:0] RND_CONST = 40'h00_0000_8000;
	localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
	localparam logic [39:0] SAT_MAX = 40'h7f_ffff_ffff;
	localparam logic [39:0] SAT_MIN = 40'h80_0000_0000;
	localparam int LOW_W = 16;
	localparam int EXT_MSB = 39;
	localparam int EXT_LSB = 31;
	typedef enum logic [2:0] {
		MMA_IDLE = 3'b001,
		MMA_EXEC = 3'b010,
		MMA_DONE = 3'b100
	} mma_state_t;
endpackage

// ===== src/mma_decode.sv
// opcode decode for the multiply-accumulate-and-move family
// assumes a four-byte instruction already collected by the core
`timescale 1ns/1ps
`default_nettype none
module mma_decode (
	input wire logic [7:0] byte0,
	input wire logic [7:0] byte2,
	output logic valid,
	output logic signed_op1,
	output logic subtract,
	output logic round
);
	import mma_pkg::*;
	always_comb begin
		valid = 1'b0;
		signed_op1 = 1'b0;
		subtract = 1'b0;
		round = 1'b0;
		if (byte0 == FIRST_BYTE) begin
			case (byte2)
				OPC_U_ADD: begin
					valid = 1'b1;
				end
				OPC_U_ADD_RND: begin
					valid = 1'b1;
					round = 1'b1;
				end
				OPC_SU_ADD: begin
					valid = 1'b1;
					signed_op1 = 1'b1;
				end
				OPC_SU_ADD_RND: begin
					valid = 1'b1;
					signed_op1 = 1'b1;
					round = 1'b1;
				end
				OPC_SU_SUB: begin
					valid = 1'b1;
					signed_op1 = 1'b1;
					subtract = 1'b1;
				end
				OPC_U_SUB: begin
					valid = 1'b1;
					subtract = 1'b1;
				end
				default: begin
					valid = 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== src/mma_unit.sv
// multiply-accumulate-and-move datapath with its flag set
// assumes operands already read from the data memory; issues one memory write
// Overview of operation
// - unsigned forms multiply 16x16 unsigned, zero-extend the 32-bit product.
// - signed-unsigned forms treat first operand signed, second unsigned.
// - signed-unsigned product is sign-extended to 40 bits.
// - additive forms add extended product into the accumulator.
// - subtracting forms subtract extended product from the accumulator.
// - rounding forms add 00_0000_8000 to the result.
// - rounding forms clear the low accumulator word.
// - copy the word addressed by the source pointer elsewhere in memory.
// - move destination comes from the pointer update.
// - move happens in the same instruction as the arithmetic.
// - additive overflow flag set when 40-bit signed result overflows.
// - subtracting forms set overflow flag on underflow.
// - sticky overflow set on additive overflow, else held.
// - sticky overflow set on underflow, else held.
// - sticky limit flag set when result saturated, else held.
// - extension flag set when result uses the extension byte.
// - additive forms set carry flag on carry out.
// - subtracting forms set carry flag on borrow.
// - zero flag set when stored result is zero.
// - negative flag follows the stored result's top bit.
// - first byte 93, third byte 18, 19, 28, 58, 59, 68 select the forms.
`timescale 1ns/1ps
`default_nettype none
module mma_unit #(
	parameter int ACC_WIDTH = 40
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic issue,
	input wire logic [7:0] opcode_byte0,
	input wire logic [7:0] opcode_byte2,
	input wire logic [mma_pkg::OP_W-1:0] operand_a,
	input wire logic [mma_pkg::OP_W-1:0] operand_word_register,
	input wire logic [mma_pkg::OP_W-1:0] move_data,
	input wire logic [mma_pkg::ADDR_W-1:0] move_source_pointer,
	input wire logic [mma_pkg::ADDR_W-1:0] pointer_modifier,
	input wire logic pointer_decrement,
	input wire logic saturate_enable,
	output logic busy,
	output logic done,
	output logic illegal_opcode,
	output logic [mma_pkg::ACC_W-1:0] product_sum_register,
	output logic mem_wr_en,
	output logic [mma_pkg::ADDR_W-1:0] mem_wr_addr,
	output logic [mma_pkg::OP_W-1:0] mem_wr_data,
	output logic result_overflow_flag,
	output logic sticky_limit_flag,
	output logic extension_used_flag,
	output logic sticky_overflow_flag,
	output logic carry_borrow_flag,
	output logic zero_result_flag,
	output logic negative_result_flag
);
	import mma_pkg::*;

	if (ACC_WIDTH != ACC_W) begin : g_chk
		$error("accumulator width must be 40");
	end

	// decoded form, only meaningful while the opcode bytes stand with issue
	logic dec_valid;
	logic dec_signed;
	logic dec_sub;
	logic dec_rnd;
	mma_decode u_dec (
		.byte0(opcode_byte0),
		.byte2(opcode_byte2),
		.valid(dec_valid),
		.signed_op1(dec_signed),
		.subtract(dec_sub),
		.round(dec_rnd)
	);

	// state and result registers; flags hold until the next accepted form
	mma_state_t st_q;
	mma_state_t st_d;
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic busy_q;
	logic busy_d;
	logic done_q;
	logic done_d;
	logic ill_q;
	logic ill_d;
	logic wr_q;
	logic wr_d;
	logic [ADDR_W-1:0] wa_q;
	logic [ADDR_W-1:0] wa_d;
	logic [OP_W-1:0] wd_q;
	logic [OP_W-1:0] wd_d;
	logic ov_q;
	logic ov_d;
	logic sl_q;
	logic sl_d;
	logic ext_q;
	logic ext_d;
	logic sv_q;
	logic sv_d;
	logic cy_q;
	logic cy_d;
	logic z_q;
	logic z_d;
	logic n_q;
	logic n_d;

	// arithmetic operands latched at issue, so execution is one cycle later
	logic [OP_W-1:0] a_q;
	logic [OP_W-1:0] a_d;
	logic [OP_W-1:0] b_q;
	logic [OP_W-1:0] b_d;
	logic sgn_q;
	logic sgn_d;
	logic sub_q;
	logic sub_d;
	logic rnd_q;
	logic rnd_d;

	// datapath terms, from the latched operands except saturate_enable, which is read live in the execute cycle
	logic [PROD_W-1:0] prod;
	logic [ACC_W-1:0] ext_prod;
	// one spare bit on the sums carries the carry or borrow out
	logic [ACC_W:0] sum1;
	logic [ACC_W:0] sum2;
	logic [ACC_W-1:0] res;
	logic [ACC_W-1:0] final_res;
	logic ovf;
	logic cy;
	logic sat;
	logic signed [OP_W:0] a_ext;
	logic signed [OP_W:0] b_ext;
	logic signed [2*OP_W+1:0] sprod;

	always_comb begin
		a_ext = sgn_q ? {a_q[OP_W-1], a_q} : {1'b0, a_q};
		b_ext = {1'b0, b_q};
		// one 17x17 signed multiply serves both the plain and the mixed-sign forms
		sprod = a_ext * b_ext;
		prod = sprod[PROD_W-1:0];
		// sign-extend only when the first operand is signed
		ext_prod = sgn_q ? {{(ACC_W-PROD_W){prod[PROD_W-1]}}, prod}
			: {{(ACC_W-PROD_W){1'b0}}, prod};
		if (sub_q) begin
			sum1 = {1'b0, acc_q} - {1'b0, ext_prod};
		end else begin
			sum1 = {1'b0, acc_q} + {1'b0, ext_prod};
		end
		sum2 = rnd_q ? {1'b0, sum1[ACC_W-1:0]} + {1'b0, RND_CONST} : sum1;
		res = sum2[ACC_W-1:0];
		// carry reflects the accumulate step; rounding carry folded in
		cy = sum1[ACC_W] ^ (rnd_q & sum2[ACC_W]);
		// signed overflow over both steps, judged by sign of operands and result
		ovf = sub_q ? ((acc_q[EXT_MSB] != ext_prod[EXT_MSB]) && (res[EXT_MSB] != acc_q[EXT_MSB]))
			: ((acc_q[EXT_MSB] == ext_prod[EXT_MSB]) && (res[EXT_MSB] != acc_q[EXT_MSB]));
		sat = saturate_enable & ovf;
		// clamp side from the old sign: an overflowing add keeps the operands' sign
		if (sat) begin
			final_res = acc_q[EXT_MSB] ? SAT_MIN : SAT_MAX;
		end else begin
			final_res = res;
		end
		// cleared after the clamp too, so a saturated rounded result keeps it
		if (rnd_q) begin
			final_res[LOW_W-1:0] = '0;
		end
	end

	always_comb begin
		st_d = st_q;
		acc_d = acc_q;
		busy_d = 1'b0;
		done_d = 1'b0;
		ill_d = ill_q;
		wr_d = 1'b0;
		wa_d = wa_q;
		wd_d = wd_q;
		a_d = a_q;
		b_d = b_q;
		sgn_d = sgn_q;
		sub_d = sub_q;
		rnd_d = rnd_q;
		ov_d = ov_q;
		sl_d = sl_q;
		ext_d = ext_q;
		sv_d = sv_q;
		cy_d = cy_q;
		z_d = z_q;
		n_d = n_q;
		case (st_q)
			MMA_IDLE: begin
				if (issue) begin
					// an unknown code leaves accumulator, flags and memory untouched
					ill_d = ~dec_valid;
					if (dec_valid) begin
						a_d = operand_a;
						b_d = operand_word_register;
						sgn_d = dec_signed;
						sub_d = dec_sub;
						rnd_d = dec_rnd;
						busy_d = 1'b1;
						st_d = MMA_EXEC;
						// move issued with the operand reads, same instruction
						wr_d = 1'b1;
						wd_d = move_data;
						// pointer arithmetic wraps at 16 bits; bounds are the core's concern
						wa_d = pointer_decrement ? move_source_pointer - 16'h0001
							: move_source_pointer + pointer_modifier;
					end
				end
			end
			MMA_EXEC: begin
				acc_d = final_res;
				// flags written together with the accumulator
				ov_d = ovf;
				sv_d = sv_q | ovf;
				sl_d = sl_q | sat;
				// nine bits: the extension byte and the top bit of the word below it
				ext_d = (final_res[EXT_MSB:EXT_LSB] != '0)
					&& (final_res[EXT_MSB:EXT_LSB] != '1);
				cy_d = cy;
				z_d = (final_res == '0);
				n_d = final_res[EXT_MSB];
				done_d = 1'b1;
				st_d = MMA_DONE;
			end
			// spare cycle; a new issue is ignored until the unit is idle again
			MMA_DONE: begin
				st_d = MMA_IDLE;
			end
			default: begin
				st_d = MMA_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= MMA_IDLE;
			acc_q <= ACC_RST;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			ill_q <= 1'b0;
			wr_q <= 1'b0;
			wa_q <= '0;
			wd_q <= '0;
			a_q <= '0;
			b_q <= '0;
			sgn_q <= 1'b0;
			sub_q <= 1'b0;
			rnd_q <= 1'b0;
			ov_q <= 1'b0;
			sl_q <= 1'b0;
			ext_q <= 1'b0;
			sv_q <= 1'b0;
			cy_q <= 1'b0;
			z_q <= 1'b0;
			n_q <= 1'b0;
		end else begin
			st_q <= st_d;
			acc_q <= acc_d;
			busy_q <= busy_d;
			done_q <= done_d;
			ill_q <= ill_d;
			wr_q <= wr_d;
			wa_q <= wa_d;
			wd_q <= wd_d;
			a_q <= a_d;
			b_q <= b_d;
			sgn_q <= sgn_d;
			sub_q <= sub_d;
			rnd_q <= rnd_d;
			ov_q <= ov_d;
			sl_q <= sl_d;
			ext_q <= ext_d;
			sv_q <= sv_d;
			cy_q <= cy_d;
			z_q <= z_d;
			n_q <= n_d;
		end
	end

	// every output comes straight from a register
	assign busy = busy_q;
	assign done = done_q;
	assign illegal_opcode = ill_q;
	assign product_sum_register = acc_q;
	assign mem_wr_en = wr_q;
	assign mem_wr_addr = wa_q;
	assign mem_wr_data = wd_q;
	assign result_overflow_flag = ov_q;
	assign sticky_limit_flag = sl_q;
	assign extension_used_flag = ext_q;
	assign sticky_overflow_flag = sv_q;
	assign carry_borrow_flag = cy_q;
	assign zero_result_flag = z_q;
	assign negative_result_flag = n_q;
endmodule
`default_nettype wire

// ===== bench/mma_monitor.sv
// port assertions for the multiply-accumulate-and-move unit
// assumes a bind from the bench top and one core clock
`timescale 1ns/1ps
`default_nettype none
module mma_monitor (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic issue,
	input wire logic [7:0] opcode_byte0,
	input wire logic [7:0] opcode_byte2,
	input wire logic [15:0] move_data,
	input wire logic [15:0] move_source_pointer,
	input wire logic [15:0] pointer_modifier,
	input wire logic pointer_decrement,
	input wire logic busy,
	input wire logic done,
	input wire logic illegal_opcode,
	input wire logic [39:0] product_sum_register,
	input wire logic mem_wr_en,
	input wire logic [15:0] mem_wr_addr,
	input wire logic [15:0] mem_wr_data,
	input wire logic extension_used_flag,
	input wire logic sticky_overflow_flag
);
	import mma_pkg::*;
	logic take;
	logic legal;
	assign take = issue && !busy && !done;
	assign legal = opcode_byte0 == FIRST_BYTE && opcode_byte2 inside {OPC_U_ADD, OPC_U_ADD_RND,
		OPC_SU_ADD, OPC_SU_ADD_RND, OPC_SU_SUB, OPC_U_SUB};
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	issue_answer_a: assert property (take && legal |=> busy && mem_wr_en ##1 done)
		else $error("issue not answered");
	move_addr_a: assert property (take && legal |=> mem_wr_addr == ($past(pointer_decrement) ?
		$past(move_source_pointer) - 16'h1 : $past(move_source_pointer) + $past(pointer_modifier)))
		else $error("move address wrong");
	move_data_a: assert property (take && legal |=> mem_wr_data == $past(move_data))
		else $error("move data wrong");
	illegal_refused_a: assert property (take && !legal |=> !mem_wr_en && illegal_opcode)
		else $error("bad opcode not refused");
	round_low_a: assert property (take && legal && opcode_byte2[0] |=> ##1
		product_sum_register[15:0] == 16'h0) else $error("low word not cleared");
	acc_at_done_a: assert property ($changed(product_sum_register) |-> done)
		else $error("accumulator moved off done");
	ext_flag_a: assert property (done |-> extension_used_flag ==
		!(product_sum_register[EXT_MSB:EXT_LSB] inside {9'h0, 9'h1ff})) else $error("ext flag");
	sticky_hold_a: assert property (sticky_overflow_flag |=> sticky_overflow_flag)
		else $error("sticky overflow lost");
	cover property (take && legal && opcode_byte2[0]);
	cover property (take && !legal);
	cover property (done && sticky_overflow_flag);
endmodule
`default_nettype wire

// ===== bench/mma_mem_model.sv
// data memory model feeding the move port and taking its write
// assumes only the low four address bits matter, to keep it small
`timescale 1ns/1ps
`default_nettype none
module mma_mem_model (
	input wire logic core_clk,
	input wire logic wr_en,
	input wire logic [15:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [15:0] rd_addr,
	output logic [15:0] rd_data,
	input wire logic [15:0] chk_addr,
	output logic [15:0] chk_data
);
	logic [15:0] mem_q [16];
	initial for (int i = 0; i < 16; i++) mem_q[i] = 16'ha500 + 16'(i);
	always @(posedge core_clk) if (wr_en) mem_q[wr_addr[3:0]] <= wr_data;
	assign rd_data = mem_q[rd_addr[3:0]];
	assign chk_data = mem_q[chk_addr[3:0]];
endmodule
`default_nettype wire

// ===== bench/mma_unit_test.sv
// self-checking bench for the multiply-accumulate-and-move unit
// assumes the memory model and the bound port monitor
`timescale 1ns/1ps
`default_nettype none
module mma_unit_test;
	import mma_pkg::*;
	logic core_clk = 0, sys_rst = 1, issue = 0, dec = 0, sat = 0;
	logic [7:0] b0 = 8'h0, b2 = 8'h0;
	logic [15:0] opa = 16'h0, opb = 16'h0, ptr = 16'h0, pmod = 16'h0, kk = 16'h0, chk_a = 16'h0;
	logic [15:0] mdata, chk_d, mwa, mwd;
	logic busy, done, ill, mwe, ovf, slim, ext, sov, cy, zf, nf;
	logic [39:0] acc, e_acc = 40'h0;
	logic e_sov = 0, e_sl = 0;
	int err_count = 0, comparisons = 0;
	mma_unit dut (.core_clk(core_clk), .sys_rst(sys_rst), .issue(issue), .opcode_byte0(b0),
		.opcode_byte2(b2), .operand_a(opa), .operand_word_register(opb), .move_data(mdata),
		.move_source_pointer(ptr), .pointer_modifier(pmod), .pointer_decrement(dec),
		.saturate_enable(sat), .busy(busy), .done(done), .illegal_opcode(ill),
		.product_sum_register(acc), .mem_wr_en(mwe), .mem_wr_addr(mwa), .mem_wr_data(mwd),
		.result_overflow_flag(ovf), .sticky_limit_flag(slim), .extension_used_flag(ext),
		.sticky_overflow_flag(sov), .carry_borrow_flag(cy), .zero_result_flag(zf),
		.negative_result_flag(nf));
	mma_mem_model mem (.core_clk(core_clk), .wr_en(mwe), .wr_addr(mwa), .wr_data(mwd),
		.rd_addr(ptr), .rd_data(mdata), .chk_addr(chk_a), .chk_data(chk_d));
	task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic send(logic [7:0] f, logic [7:0] op, logic [15:0] a, logic [15:0] b, logic s);
		@(posedge core_clk);
		issue <= 1; b0 <= f; b2 <= op; opa <= a; opb <= b; sat <= s;
		ptr <= kk; pmod <= 16'h3; dec <= kk[0];
		@(posedge core_clk);
		issue <= 0;
	endtask
	task automatic run(logic [7:0] op, logic [15:0] a, logic [15:0] b, logic s);
		logic [39:0] pe, r;
		logic [40:0] sm, rs;
		logic ov;
		logic [15:0] wd;
		int n;
		pe = op[6] ? {{24{a[15]}}, a} * {24'h0, b} : {24'h0, a} * {24'h0, b};
		sm = op[5] ? {1'b0, e_acc} - {1'b0, pe} : {1'b0, e_acc} + {1'b0, pe};
		rs = {1'b0, sm[39:0]} + {1'b0, RND_CONST};
		r = op[0] ? rs[39:0] : sm[39:0];
		ov = (e_acc[39] ^ r[39]) & (op[5] ^ ~(e_acc[39] ^ pe[39]));
		if (s && ov) r = e_acc[39] ? SAT_MIN : SAT_MAX;
		if (op[0]) r[15:0] = 16'h0;
		e_sov |= ov;
		e_sl |= s & ov;
		send(FIRST_BYTE, op, a, b, s);
		wd = mdata;
		for (n = 0; n < 8 && done !== 1'b1; n++) @(posedge core_clk);
		if (done !== 1'b1) begin
			err_count++;
			stop_test;
		end
		check("acc", acc, r);
		check("zero", zf, r == 40'h0);
		check("neg", nf, r[39]);
		check("ovf", ovf, ov);
		check("sticky ovf", sov, e_sov);
		check("limit", slim, e_sl);
		check("illegal", ill, 1'b0);
		check("carry", cy, sm[40] ^ (op[0] & rs[40]));
		chk_a = kk[0] ? kk - 16'h1 : kk + 16'h3;
		#1;
		check("moved", chk_d, wd);
		e_acc = r;
		kk++;
	endtask
	initial forever #2.5 core_clk = ~core_clk;
	initial begin
		repeat (8) @(posedge core_clk);
		check("acc reset", acc, 40'h0);
		sys_rst <= 0;
		run(OPC_U_ADD, 16'hffff, 16'hffff, 0);
		run(OPC_SU_ADD, 16'hffff, 16'h0002, 0);
		run(OPC_SU_SUB, 16'h8000, 16'hffff, 0);
		run(OPC_U_ADD_RND, 16'h1234, 16'h0010, 0);
		run(OPC_SU_ADD_RND, 16'h8001, 16'h7fff, 0);
		run(OPC_U_SUB, 16'h0001, 16'h0001, 0);
		// unknown third byte, then a wrong first byte
		for (int i = 0; i < 2; i++) begin
			send(i ? 8'h92 : FIRST_BYTE, i ? OPC_U_ADD : 8'h00, 16'h5, 16'h5, 0);
			repeat (3) @(posedge core_clk);
			check("illegal", ill, 1'b1);
			check("acc kept", acc, e_acc);
		end
		for (int i = 0; i < 140; i++) run(OPC_U_ADD, 16'hffff, 16'hffff, 1);
		run(OPC_U_ADD_RND, 16'hffff, 16'hffff, 1);
		// the first underflow clamps to the minimum, the next one wraps
		for (int i = 0; i < 260; i++) run(OPC_U_SUB, 16'hffff, 16'hffff, i == 256);
		stop_test;
	end
endmodule
bind mma_unit mma_monitor mon (.core_clk(core_clk), .sys_rst(sys_rst), .issue(issue),
	.opcode_byte0(opcode_byte0), .opcode_byte2(opcode_byte2), .move_data(move_data),
	.move_source_pointer(move_source_pointer), .pointer_modifier(pointer_modifier),
	.pointer_decrement(pointer_decrement), .busy(busy), .done(done),
	.illegal_opcode(illegal_opcode), .product_sum_register(product_sum_register),
	.mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
	.extension_used_flag(extension_used_flag), .sticky_overflow_flag(sticky_overflow_flag));
`default_nettype wire
